// ==== include/mdc_regs.svh ====
// register map, field positions and timing constants of the modem dial control block
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH

`define MDC_ADDR_W 8
`define MDC_OFS_MODE 8'h00
`define MDC_OFS_NUM0 8'h04
`define MDC_OFS_NUM5 8'h18
`define MDC_OFS_CTRL 8'h1C
`define MDC_OFS_STAT 8'h20
`define MDC_OFS_PORT 8'h24

`define MDC_MODE_PROG 8'h55
`define MDC_MODE_DED 8'hAA
`define MDC_MODE_RST 16'h0000
`define MDC_NUM_RST 16'h0000

`define MDC_NIB_PAUSE 4'hA
`define MDC_NIB_MAX 4'hC
`define MDC_NIB_END 4'hE
`define MDC_NIBS 24
`define MDC_IDX_LAST 5'd23
`define MDC_REDIAL_MAX 2'd3

`define MDC_CTRL_DIAL 0
`define MDC_STAT_VALID 8
`define MDC_STAT_OWNED 9
`define MDC_STAT_CONN 10

`define MDC_CLK_KHZ 20000
`define MDC_PAUSE_MS 2000
`define MDC_REDIAL_SPAN_MS 180000
`define MDC_PAUSE_CYC (`MDC_PAUSE_MS * `MDC_CLK_KHZ)
`define MDC_GAP_CYC ((`MDC_REDIAL_SPAN_MS / 3) * `MDC_CLK_KHZ)

`endif

// ==== include/mdc_pkg.sv ====
// types shared by the modem dial control block
package mdc_pkg;

  typedef enum logic [2:0] {
    MDC_IDLE = 3'b000,
    MDC_EVAL = 3'b001,
    MDC_DIAL = 3'b010,
    MDC_PAUSE = 3'b011,
    MDC_WAITC = 3'b100,
    MDC_GAP = 3'b101,
    MDC_ANSWER = 3'b110,
    MDC_CONN = 3'b111
  } mdc_state_e;

  typedef logic [15:0] mdc_word_t;

endpackage

// ==== verilog/mdc_top.sv ====
// modem dial and connection control for serial port 1, with port 1..4 status flags
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"

// Contract
// - mode 55h: program-controlled dialing on port 1
// - mode AAh: dedicated modem, answer and dial
// - other mode values disable all modem behaviour
// - dedicated: own port until connected, then release
// - no number: answer, connect on good inbound
// - number evaluated only at power off-to-on
// - valid number at power-on: dial, then connect
// - up to three redials, then answer mode in mode AAh, idle in mode 55h
// - digits 0-9, A pause, B hash, C star, E end
// - 24 nibbles read from word0 nibble0 upward
// - valid only if E-terminated, earlier nibbles 0-C
// - callback: dial latest written number at once
// - ports 1-4 become program type on use
// - ascii output on port 1 is transmit only
// - modbus master instruction makes ports masters
// - each port has ready and done flags
module mdc_top
  import mdc_pkg::*;
#(
  parameter int unsigned PAUSE_CYC = `MDC_PAUSE_CYC,
  parameter int unsigned GAP_CYC = `MDC_GAP_CYC
)
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MDC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power levels of host and modem
  input wire logic host_pwr_on,
  input wire logic modem_pwr_on,
  // modem side
  input wire logic modem_carrier,
  input wire logic modem_inbound_ok,
  input wire logic modem_dial_fail,
  input wire logic remote_callback,
  input wire logic remote_shutdown,
  output logic modem_answer_en,
  output logic [3:0] dial_digit,
  output logic dial_digit_stb,
  output logic dial_done,
  output logic modem_hangup,
  output logic port1_modem_owned,
  output logic port1_rx_en,
  // program instruction use, ports 1..4 on bits 0..3
  input wire logic [3:0] mbus_master_use,
  input wire logic [3:0] link_use,
  input wire logic ascii_out_active,
  input wire logic [3:0] txn_start,
  input wire logic [3:0] txn_end,
  output logic [3:0] port_prog_type,
  output logic [3:0] port_mbus_master,
  output logic [3:0] port_ready,
  output logic [3:0] port_done
);

  // ****************************************
  // register file over apb
  // ****************************************
  mdc_word_t mode_reg;
  mdc_word_t num_reg [6];
  logic [95:0] shadow_reg;
  logic [95:0] live_num;
  logic [31:0] rd_data;
  logic [31:0] stat_word;
  logic [31:0] port_word;
  logic acc_phase;
  logic wr_fire;
  logic hit_num;
  logic hit_any;
  logic [2:0] num_sel;
  logic dial_go;
  mdc_state_e state_reg;
  mdc_state_e state_next;
  logic [1:0] redial_reg;
  logic num_valid;

  assign acc_phase = psel & penable;
  // writes land only on the edge where the master sees pready
  assign wr_fire = ce & acc_phase & pready & pwrite;
  assign hit_num = (paddr >= `MDC_OFS_NUM0) && (paddr <= `MDC_OFS_NUM5) && (paddr[1:0] == 2'b00);
  assign num_sel = 3'((paddr - `MDC_OFS_NUM0) >> 2);
  assign hit_any = (paddr == `MDC_OFS_MODE) || hit_num || (paddr == `MDC_OFS_CTRL)
                   || (paddr == `MDC_OFS_STAT) || (paddr == `MDC_OFS_PORT);
  assign dial_go = wr_fire && (paddr == `MDC_OFS_CTRL) && pwdata[`MDC_CTRL_DIAL];

  assign stat_word = {21'h00_0000, (state_reg == MDC_CONN), port1_modem_owned, num_valid,
                      2'b00, redial_reg, 1'b0, state_reg};
  assign port_word = {20'h0_0000, port_prog_type, port_done, port_ready};
  assign rd_data = (paddr == `MDC_OFS_MODE) ? {16'h0000, mode_reg} :
                   hit_num ? {16'h0000, num_reg[num_sel]} :
                   (paddr == `MDC_OFS_STAT) ? stat_word :
                   (paddr == `MDC_OFS_PORT) ? port_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      // one wait state: answer in the second access cycle
      pready <= acc_phase & ~pready;
      pslverr <= acc_phase & ~pready & ~hit_any;
      prdata <= (acc_phase & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= `MDC_MODE_RST;
    else if (wr_fire && (paddr == `MDC_OFS_MODE))
      mode_reg <= pwdata[15:0];
  end

  genvar gw;
  generate
    for (gw = 0; gw < 6; gw++)
    begin : g_num
      assign live_num[gw*16 +: 16] = num_reg[gw];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          num_reg[gw] <= `MDC_NUM_RST;
        else if (wr_fire && hit_num && (num_sel == 3'(gw)))
          num_reg[gw] <= pwdata[15:0];
      end
    end
  endgenerate

  // ****************************************
  // number check
  // ****************************************
  logic [`MDC_NIBS:0] end_seen;
  logic [`MDC_NIBS:0] bad_seen;
  logic [3:0] cur_nib;
  logic [4:0] idx_reg;

  assign end_seen[0] = 1'b0;
  assign bad_seen[0] = 1'b0;
  genvar gn;
  generate
    for (gn = 0; gn < `MDC_NIBS; gn++)
    begin : g_chk
      // nibbles after the end marker are ignored
      assign end_seen[gn+1] = end_seen[gn] | (shadow_reg[gn*4 +: 4] == `MDC_NIB_END);
      assign bad_seen[gn+1] = bad_seen[gn] | (~end_seen[gn] & (shadow_reg[gn*4 +: 4] > `MDC_NIB_MAX)
                              & (shadow_reg[gn*4 +: 4] != `MDC_NIB_END));
    end
  endgenerate
  // an invalid number is the same as none
  assign num_valid = end_seen[`MDC_NIBS] & ~bad_seen[`MDC_NIBS];
  // nibble 0 of word 0 first, nibble 3 of word 5 last
  assign cur_nib = shadow_reg[{idx_reg, 2'b00} +: 4];

  // ****************************************
  // dial and answer state machine
  // ****************************************
  logic mode_ded;
  logic mode_prog;
  logic pwr_prev_reg;
  logic pwr_rise;
  logic [30:0] tmr_reg;
  logic tmr_done;
  logic pause_done;
  logic link_lost;
  logic cb_take;

  // only the two mode codes enable any modem behaviour; port flags run in every mode
  assign mode_ded = (mode_reg[15:8] == `MDC_MODE_DED);
  assign mode_prog = (mode_reg[15:8] == `MDC_MODE_PROG);
  // evaluation trigger is an off-to-on power edge
  assign pwr_rise = (host_pwr_on & modem_pwr_on) & ~pwr_prev_reg;
  assign tmr_done = (tmr_reg == 31'(GAP_CYC - 1));
  assign pause_done = (tmr_reg == 31'(PAUSE_CYC - 1));
  assign link_lost = remote_shutdown | ~modem_carrier;
  assign cb_take = mode_ded & remote_callback & (state_reg != MDC_IDLE);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MDC_IDLE:
        if (mode_ded && pwr_rise)
          state_next = MDC_EVAL;
        else if (mode_prog && dial_go)
          state_next = MDC_DIAL;
      MDC_EVAL:
        state_next = num_valid ? MDC_DIAL : MDC_ANSWER;
      MDC_DIAL:
        // A pauses, E ends, the rest up to C are sent, D and F are skipped
        if (cur_nib == `MDC_NIB_END || idx_reg == `MDC_IDX_LAST)
          state_next = MDC_WAITC;
        else if (cur_nib == `MDC_NIB_PAUSE)
          state_next = MDC_PAUSE;
      MDC_PAUSE:
        if (pause_done)
          state_next = MDC_DIAL;
      MDC_WAITC:
        if (modem_carrier)
          state_next = MDC_CONN;
        else if (modem_dial_fail)
          // after the third redial give up to answering when dedicated, to idle in program mode
          state_next = (redial_reg == `MDC_REDIAL_MAX) ? (mode_ded ? MDC_ANSWER : MDC_IDLE) : MDC_GAP;
      MDC_GAP:
        if (tmr_done)
          state_next = MDC_DIAL;
      MDC_ANSWER:
        // good inbound call leaves answer mode; carrier of a call being dropped is stale
        if (modem_carrier && modem_inbound_ok && !modem_hangup)
          state_next = MDC_CONN;
      MDC_CONN:
        // shutdown or carrier loss drops the link
        if (link_lost)
          state_next = mode_ded ? MDC_ANSWER : MDC_IDLE;
      default:
        state_next = MDC_IDLE;
    endcase
    // callback dials the latest written number
    if (cb_take)
      state_next = MDC_DIAL;
    // a power cycle re-evaluates the number
    if (mode_ded && pwr_rise)
      state_next = MDC_EVAL;
    if (!mode_ded && !mode_prog)
      state_next = MDC_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= MDC_IDLE;
      pwr_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      pwr_prev_reg <= host_pwr_on & modem_pwr_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shadow_reg <= 96'h0;
    // number is sampled at power-on, callback or program dial
    else if (ce && ((mode_ded && (pwr_rise || remote_callback)) || (mode_prog && dial_go)))
      shadow_reg <= live_num;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_reg <= 5'd0;
      tmr_reg <= 31'd0;
      redial_reg <= 2'd0;
    end
    else if (ce)
    begin
      idx_reg <= cb_take ? 5'd0 : (state_reg == MDC_DIAL && state_next == MDC_DIAL) ? idx_reg + 5'd1 :
                 (state_next == MDC_DIAL && state_reg != MDC_PAUSE) ? 5'd0 :
                 (state_reg == MDC_PAUSE && state_next == MDC_DIAL) ? idx_reg + 5'd1 : idx_reg;
      tmr_reg <= (state_next == state_reg && (state_reg == MDC_GAP || state_reg == MDC_PAUSE))
                 ? tmr_reg + 31'd1 : 31'd0;
      // redial count restarts on every fresh dial sequence
      if (state_reg == MDC_WAITC && state_next == MDC_GAP)
        redial_reg <= redial_reg + 2'd1;
      else if (cb_take || state_reg == MDC_IDLE || state_reg == MDC_EVAL || state_reg == MDC_ANSWER
               || state_reg == MDC_CONN)
        redial_reg <= 2'd0;
    end
  end

  // ****************************************
  // modem and port 1 outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      modem_answer_en <= 1'b0;
      dial_digit <= 4'h0;
      dial_digit_stb <= 1'b0;
      dial_done <= 1'b0;
      modem_hangup <= 1'b0;
      port1_modem_owned <= 1'b0;
      port1_rx_en <= 1'b1;
    end
    else if (ce)
    begin
      modem_answer_en <= (state_next == MDC_ANSWER);
      dial_digit_stb <= (state_reg == MDC_DIAL) && (cur_nib <= `MDC_NIB_MAX) && (cur_nib != `MDC_NIB_PAUSE);
      dial_digit <= (state_reg == MDC_DIAL) ? cur_nib : 4'h0;
      dial_done <= (state_reg != MDC_WAITC) && (state_next == MDC_WAITC);
      modem_hangup <= (state_reg == MDC_CONN) && (state_next != MDC_CONN);
      // dedicated port stays with the modem until connected
      port1_modem_owned <= mode_ded && (state_next != MDC_CONN);
      // ascii output never listens on port 1
      port1_rx_en <= ~ascii_out_active;
    end
  end

  // ****************************************
  // port 1..4 type and status flags
  // ****************************************
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_port
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          port_prog_type[gp] <= 1'b0;
          port_mbus_master[gp] <= 1'b0;
          port_ready[gp] <= 1'b1;
          port_done[gp] <= 1'b0;
        end
        else if (ce)
        begin
          // instruction use switches to program type
          port_prog_type[gp] <= mbus_master_use[gp] | link_use[gp];
          // modbus instruction polls slaves as master
          port_mbus_master[gp] <= mbus_master_use[gp];
          // ready falls on start; done set wins over clear
          port_ready[gp] <= txn_end[gp] | (port_ready[gp] & ~txn_start[gp]);
          port_done[gp] <= txn_end[gp] | (port_done[gp] & ~txn_start[gp]);
        end
      end
    end
  endgenerate

  // ****************************************
  // assertions
  // ****************************************
  property p_mode_off;
    @(posedge pclk) disable iff (!presetn)
    ce && !mode_ded && !mode_prog |=> state_reg == MDC_IDLE;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("modem state active while disabled");

  property p_owned;
    @(posedge pclk) disable iff (!presetn)
    ce && mode_ded |=> port1_modem_owned == (state_reg != MDC_CONN);
  endproperty
  a_owned: assert property (p_owned) else $error("port 1 released before connect");

  property p_answer_conn;
    @(posedge pclk) disable iff (!presetn)
    ce && mode_ded && state_reg == MDC_ANSWER && modem_carrier && modem_inbound_ok && !pwr_rise
    && !remote_callback && !modem_hangup |=> state_reg == MDC_CONN ##1 !modem_answer_en || !ce;
  endproperty
  a_answer_conn: assert property (p_answer_conn) else $error("answer did not connect");

  property p_eval;
    @(posedge pclk) disable iff (!presetn)
    ce && mode_ded && state_reg == MDC_EVAL && !pwr_rise && !remote_callback
    |=> state_reg == (num_valid ? MDC_DIAL : MDC_ANSWER);
  endproperty
  a_eval: assert property (p_eval) else $error("wrong branch after number check");

  property p_redial;
    @(posedge pclk) disable iff (!presetn)
    ce && mode_ded && state_reg == MDC_WAITC && modem_dial_fail && !modem_carrier
    && redial_reg == 2'd3 && !pwr_rise && !remote_callback |=> state_reg == MDC_ANSWER;
  endproperty
  a_redial: assert property (p_redial) else $error("no answer mode after last redial");

  property p_callback;
    @(posedge pclk) disable iff (!presetn)
    ce && mode_ded && remote_callback && state_reg != MDC_IDLE && !pwr_rise |=> state_reg == MDC_DIAL;
  endproperty
  a_callback: assert property (p_callback) else $error("callback did not start dialing");

  property p_digit;
    @(posedge pclk) disable iff (!presetn)
    dial_digit_stb |-> dial_digit <= 4'hC && dial_digit != 4'hA;
  endproperty
  a_digit: assert property (p_digit) else $error("bad digit sent to modem");

  property p_ascii;
    @(posedge pclk) disable iff (!presetn)
    ce && ascii_out_active |=> !port1_rx_en;
  endproperty
  a_ascii: assert property (p_ascii) else $error("port 1 receives during ascii output");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
    ce && txn_end[0] |=> port_done[0] && port_ready[0];
  endproperty
  a_done: assert property (p_done) else $error("done flag missed transaction end");

  property p_prog;
    @(posedge pclk) disable iff (!presetn)
    ce && (mbus_master_use[1] || link_use[1]) |=> port_prog_type[1];
  endproperty
  a_prog: assert property (p_prog) else $error("port not switched to program type");

endmodule
`default_nettype wire

// ==== verif/mdc_modem_model.sv ====
// behavioural telephone modem on the far side of the modem dial control block
`timescale 1ns/1ps
`default_nettype none
module mdc_modem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // block side
  input wire logic modem_answer_en,
  input wire logic dial_done,
  input wire logic modem_hangup,
  // bench control: fail every dial, remote rings, answer delay
  input wire logic fail_next,
  input wire logic ring,
  input wire logic [3:0] resp_dly,
  // line state
  output logic modem_carrier,
  output logic modem_inbound_ok,
  output logic modem_dial_fail
);
  logic [3:0] cnt_reg;
  logic pend_reg;
  logic call_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_reg <= '0;
      pend_reg <= 1'b0;
      call_reg <= 1'b0;
      modem_carrier <= 1'b0;
      modem_inbound_ok <= 1'b0;
      modem_dial_fail <= 1'b0;
    end
    else
    begin
      modem_dial_fail <= 1'b0;
      if (modem_hangup)
      begin
        modem_carrier <= 1'b0;
        modem_inbound_ok <= 1'b0;
        pend_reg <= 1'b0;
      end
      else if (pend_reg && cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
      else if (pend_reg)
      begin
        pend_reg <= 1'b0;
        modem_dial_fail <= call_reg && fail_next;
        modem_carrier <= !(call_reg && fail_next);
        modem_inbound_ok <= !(call_reg && fail_next);
      end
      else if (dial_done || (ring && modem_answer_en))
      begin
        pend_reg <= 1'b1;
        call_reg <= dial_done;
        cnt_reg <= resp_dly;
      end
    end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench of the modem dial control block
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"
module tb_top;
  // ****
  // signals
  // ****
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} mdc_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic host_pwr_on = 1'b0;
  logic modem_pwr_on = 1'b0;
  logic remote_callback = 1'b0;
  logic remote_shutdown = 1'b0;
  logic ascii_out_active = 1'b0;
  logic fail_next = 1'b0;
  logic ring = 1'b0;
  logic [3:0] mbus_master_use = '0;
  logic [3:0] link_use = '0;
  logic [3:0] txn_start = '0;
  logic [3:0] txn_end = '0;
  logic [3:0] resp_dly = '0;
  logic [31:0] prdata;
  logic pready, pslverr, modem_carrier, modem_inbound_ok, modem_dial_fail, modem_answer_en;
  logic dial_digit_stb, dial_done, modem_hangup, port1_modem_owned, port1_rx_en;
  logic [3:0] dial_digit, port_prog_type, port_mbus_master, port_ready, port_done;
  int mismatches = 0;
  int samples_checked = 0;
  int ndone = 0;
  int nhang = 0;
  logic [3:0] dq[$];
  logic [31:0] rd;
  logic er;
  mdc_row_s rows [10] = '{
    '{1'b1, `MDC_OFS_MODE, 32'h0000_AA00, 32'h0, 1'b0},
    '{1'b0, `MDC_OFS_MODE, 32'h0, 32'h0000_AA00, 1'b0},
    '{1'b1, `MDC_OFS_NUM0, 32'hFFFF_E321, 32'h0, 1'b0},
    '{1'b0, `MDC_OFS_NUM0, 32'h0, 32'h0000_E321, 1'b0},
    '{1'b1, `MDC_OFS_NUM5, 32'h0000_1234, 32'h0, 1'b0},
    '{1'b0, `MDC_OFS_NUM5, 32'h0, 32'h0000_1234, 1'b0},
    '{1'b0, `MDC_OFS_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, `MDC_OFS_PORT, 32'h0, 32'h0000_000F, 1'b0},
    '{1'b0, 8'h28, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h40, 32'h0000_5555, 32'h0, 1'b1}};

  always #25 pclk = ~pclk;

  mdc_top #(.PAUSE_CYC(4), .GAP_CYC(8)) DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .host_pwr_on, .modem_pwr_on, .modem_carrier,
    .modem_inbound_ok, .modem_dial_fail, .remote_callback, .remote_shutdown, .modem_answer_en,
    .dial_digit, .dial_digit_stb, .dial_done, .modem_hangup, .port1_modem_owned, .port1_rx_en,
    .mbus_master_use, .link_use, .ascii_out_active, .txn_start, .txn_end, .port_prog_type,
    .port_mbus_master, .port_ready, .port_done);
  mdc_modem_model modem (.pclk, .presetn, .modem_answer_en, .dial_done, .modem_hangup, .fail_next,
    .ring, .resp_dly, .modem_carrier, .modem_inbound_ok, .modem_dial_fail);

  always @(posedge pclk)
  begin
    if (dial_digit_stb === 1'b1) dq.push_back(dial_digit);
    if (dial_done === 1'b1) ndone++;
    if (modem_hangup === 1'b1) nhang++;
  end

  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // entered just after a rising edge; returns one idle cycle after the transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `MDC_OFS_STAT, '0, rd, er);
      n++;
    end
    while (rd[2:0] !== s && n < 300);
    chk({29'h0, rd[2:0]}, {29'h0, s}, "state");
  endtask
  task automatic chk_digits(input logic [15:0] e, input int n, input int reps);
    chk(32'(dq.size()), 32'(n * reps), "digit count");
    for (int i = 0; i < dq.size() && i < n * reps; i++)
      chk({28'h0, dq[i]}, {28'h0, e[4 * (i % n) +: 4]}, "digit");
  endtask
  task automatic pwr_cycle;
    modem_pwr_on <= 1'b0;
    cyc(3);
    modem_pwr_on <= 1'b1;
    host_pwr_on <= 1'b1;
    cyc(1);
  endtask
  task automatic shutdown;
    remote_shutdown <= 1'b1;
    cyc(1);
    remote_shutdown <= 1'b0;
    wait_state(3'd6);
  endtask
  task automatic end_test(input string t);
    $display("test %s finished", t);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    cyc(60000);
    mismatches++;
    report_and_stop;
  end

  // ****
  // tests
  // ****
  initial
  begin
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    chk({28'h0, port_ready}, 32'h0000_000F, "ready after reset");
    chk({31'h0, modem_answer_en}, 32'h0, "answer after reset");
    end_test("reset");
    for (int i = 0; i < 10; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].w) chk(rd, rows[i].x, "read data");
      chk({31'h0, er}, {31'h0, rows[i].e}, "error flag");
    end
    end_test("registers");
    fail_next <= 1'b1;
    resp_dly <= 4'hC;
    host_pwr_on <= 1'b1;
    modem_pwr_on <= 1'b1;
    cyc(1);
    wait_state(3'd6);
    chk(32'(ndone), 32'h4, "dial attempts");
    chk_digits(16'h0321, 3, 4);
    chk({31'h0, modem_answer_en}, 32'h1, "answer mode");
    chk({31'h0, port1_modem_owned}, 32'h1, "port locked");
    end_test("redial");
    ring <= 1'b1;
    resp_dly <= 4'h1;
    cyc(1);
    ring <= 1'b0;
    wait_state(3'd7);
    chk({31'h0, rd[10]}, 32'h1, "connected");
    chk({31'h0, port1_modem_owned}, 32'h0, "port released");
    chk({31'h0, modem_answer_en}, 32'h0, "answer left");
    shutdown;
    chk(32'(nhang), 32'h1, "hangup");
    end_test("answer");
    apb(1'b0, `MDC_OFS_NUM0, '0, rd, er);
    chk(rd, 32'h0000_E321, "old number");
    apb(1'b1, `MDC_OFS_NUM0, 32'h0000_BCA4, rd, er);
    apb(1'b1, `MDC_OFS_NUM0 + 8'h04, 32'h0000_000E, rd, er);
    dq.delete();
    fail_next <= 1'b0;
    remote_callback <= 1'b1;
    cyc(1);
    remote_callback <= 1'b0;
    wait_state(3'd7);
    chk_digits(16'h0BC4, 3, 1);
    shutdown;
    end_test("callback");
    apb(1'b1, `MDC_OFS_NUM0, 32'h0000_E0D1, rd, er);
    dq.delete();
    pwr_cycle;
    cyc(20);
    wait_state(3'd6);
    chk({31'h0, rd[8]}, 32'h0, "number valid");
    chk(32'(dq.size()), 32'h0, "no dialing");
    end_test("invalid number");
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    chk({31'h0, modem_answer_en}, 32'h0, "answer after second reset");
    chk({31'h0, port1_modem_owned}, 32'h0, "owned after second reset");
    apb(1'b1, `MDC_OFS_MODE, 32'h0000_1200, rd, er);
    apb(1'b1, `MDC_OFS_NUM0, 32'h0000_E321, rd, er);
    dq.delete();
    pwr_cycle;
    cyc(20);
    wait_state(3'd0);
    chk(32'(dq.size()), 32'h0, "no dialing");
    chk({31'h0, modem_answer_en}, 32'h0, "no answer");
    end_test("disabled mode");
    mbus_master_use <= 4'b0100;
    link_use <= 4'b1000;
    ascii_out_active <= 1'b1;
    txn_start <= 4'b0010;
    cyc(1);
    txn_start <= '0;
    cyc(1);
    chk({28'h0, port_ready}, 32'h0000_000D, "ready cleared");
    txn_end <= 4'b0010;
    cyc(1);
    txn_end <= '0;
    cyc(1);
    chk({28'h0, port_done}, 32'h0000_0002, "done set");
    chk({28'h0, port_mbus_master}, 32'h0000_0004, "master");
    chk({31'h0, port1_rx_en}, 32'h0, "receive off");
    apb(1'b0, `MDC_OFS_PORT, '0, rd, er);
    chk(rd, 32'h0000_0C2F, "port status");
    // a start pulse while the clock enable is low must leave the flags frozen
    ce <= 1'b0;
    txn_start <= 4'b0001;
    cyc(1);
    ce <= 1'b1;
    txn_start <= '0;
    cyc(1);
    chk({28'h0, port_ready}, 32'h0000_000F, "ready frozen");
    end_test("port flags");
    report_and_stop;
  end
endmodule
`default_nettype wire
